// ==== logic/nfp_host_ctrl.v ====
// Host controller issuing feature get/set cycles to a NAND device
`include "nfp_consts.vh"

module nfp_host_ctrl #(
	parameter PWRUP_CYC = `NFP_PWRUP_CYC
) (
	// Clock and reset
	input  wire        CLK,
	input  wire        RST,
	// User side
	input  wire        REQ_GET,
	input  wire        REQ_SET,
	input  wire [7:0]  REQ_ADDR,
	input  wire [31:0] REQ_WDATA,
	input  wire        WP_ENABLE,
	output reg         READY,
	output reg         DONE,
	output reg  [31:0] RDATA,
	// NAND pins
	output reg         NAND_CE_N,
	output reg         NAND_CLE,
	output reg         NAND_ALE,
	output reg         NAND_WE_N,
	output reg         READ_STROBE_N,
	output reg         NAND_WP_N,
	input  wire        NAND_RB_N,
	input  wire [7:0]  NAND_IO_I,
	output reg  [7:0]  NAND_IO_O,
	output reg         NAND_IO_OE
);

	// ********************************************
	// States
	// ********************************************
	localparam S_PWR  = 4'h0;
	localparam S_IDLE = 4'h1;
	localparam S_WPS  = 4'h2;
	localparam S_CMD  = 4'h3;
	localparam S_ADR  = 4'h4;
	localparam S_WDAT = 4'h5;
	localparam S_BSY0 = 4'h6;
	localparam S_BSY  = 4'h7;
	localparam S_RDLO = 4'h8;
	localparam S_RDHI = 4'h9;
	localparam S_FIN  = 4'hA;

	// ********************************************
	// Timing limits
	// ********************************************
	// Cut to the counter width on purpose; all limits fit in 20 bits
	localparam integer PWR_INT  = PWRUP_CYC - 1;
	localparam integer WPS_INT  = `NFP_WP_SETUP_CYC;
	localparam integer RHW_INT  = `NFP_RHW_CYC;
	localparam [19:0]  PWR_LAST = PWR_INT[19:0];
	localparam [19:0]  WPS_LAST = WPS_INT[19:0];
	localparam [19:0]  RHW_LAST = RHW_INT[19:0];

	// ********************************************
	// Registers
	// ********************************************
	reg  [3:0]  st_q;
	reg  [19:0] cnt_q;
	reg  [1:0]  byte_q;
	reg         ph_q;
	reg         is_set_q;
	reg  [7:0]  addr_q;
	reg  [31:0] wdat_q;

	// ********************************************
	// Helpers
	// ********************************************
	// Byte k of a parameter word; P1 travels first and sits lowest
	function [7:0] pick_byte;
		input [31:0] w;
		input [1:0]  k;
		begin
			pick_byte = w[8*k +: 8];
		end
	endfunction

	// ********************************************
	// Sequencer
	// ********************************************
	// Two-phase strobe: phase 0 low, phase 1 high (rising edge latches)
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_q          <= S_PWR;
			cnt_q         <= 20'h00000;
			byte_q        <= 2'h0;
			ph_q          <= 1'b0;
			is_set_q      <= 1'b0;
			addr_q        <= 8'h00;
			wdat_q        <= 32'h00000000;
			READY         <= 1'b0;
			DONE          <= 1'b0;
			RDATA         <= 32'h00000000;
			NAND_CE_N     <= 1'b1;
			NAND_CLE      <= 1'b0;
			NAND_ALE      <= 1'b0;
			NAND_WE_N     <= 1'b1;
			READ_STROBE_N <= 1'b1;
			NAND_WP_N     <= 1'b0;
			NAND_IO_O     <= 8'h00;
			NAND_IO_OE    <= 1'b0;
		end else begin
			DONE <= 1'b0;
			case (st_q)
			S_PWR: begin
				if (cnt_q == PWR_LAST) begin
					cnt_q <= 20'h00000;
					st_q  <= S_IDLE;
					READY <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 20'h00001;
				end
			end
			S_IDLE: begin
				NAND_CE_N <= 1'b1;
				// Requests are only looked at here; while busy they drop
				if (REQ_GET || REQ_SET) begin
					READY    <= 1'b0;
					is_set_q <= REQ_SET & ~REQ_GET;
					addr_q   <= REQ_ADDR;
					wdat_q   <= REQ_WDATA;
					cnt_q    <= 20'h00000;
					st_q     <= S_WPS;
				end else begin
					NAND_WP_N <= WP_ENABLE ? 1'b0 : 1'b1;
				end
			end
			S_WPS: begin
				if (cnt_q >= WPS_LAST) begin
					cnt_q     <= 20'h00000;
					NAND_CE_N <= 1'b0;
					ph_q      <= 1'b0;
					st_q      <= S_CMD;
				end else begin
					cnt_q <= cnt_q + 20'h00001;
				end
			end
			S_CMD: begin
				NAND_CLE   <= 1'b1;
				NAND_IO_OE <= 1'b1;
				NAND_IO_O  <= is_set_q ? `NFP_CMD_SET_FEAT :
				              `NFP_CMD_GET_FEAT;
				NAND_WE_N  <= ph_q;
				ph_q       <= ~ph_q;
				if (ph_q) begin
					st_q <= S_ADR;
				end
			end
			S_ADR: begin
				NAND_CLE  <= 1'b0;
				NAND_ALE  <= 1'b1;
				NAND_IO_O <= addr_q;
				NAND_WE_N <= ph_q;
				ph_q      <= ~ph_q;
				if (ph_q) begin
					byte_q <= 2'h0;
					st_q   <= is_set_q ? S_WDAT : S_BSY0;
				end
			end
			S_WDAT: begin
				NAND_ALE  <= 1'b0;
				NAND_IO_O <= pick_byte(wdat_q, byte_q);
				NAND_WE_N <= ph_q;
				ph_q      <= ~ph_q;
				if (ph_q) begin
					byte_q <= byte_q + 2'h1;
					if (byte_q == 2'h3) begin
						st_q <= S_BSY0;
					end
				end
			end
			S_BSY0: begin
				// Give the device time to pull busy low
				NAND_ALE   <= 1'b0;
				NAND_IO_OE <= 1'b0;
				if (cnt_q >= RHW_LAST) begin
					cnt_q <= 20'h00000;
					st_q  <= S_BSY;
				end else begin
					cnt_q <= cnt_q + 20'h00001;
				end
			end
			S_BSY: begin
				// busy pin watched, no status read to recover from
				// No timeout: a device that never goes ready hangs here
				if (NAND_RB_N) begin
					byte_q <= 2'h0;
					st_q   <= is_set_q ? S_FIN : S_RDLO;
				end
			end
			S_RDLO: begin
				READ_STROBE_N <= 1'b0;
				st_q          <= S_RDHI;
			end
			S_RDHI: begin
				READ_STROBE_N          <= 1'b1;
				RDATA[8*byte_q +: 8]   <= NAND_IO_I;
				byte_q                 <= byte_q + 2'h1;
				st_q <= (byte_q == 2'h3) ? S_FIN : S_RDLO;
			end
			S_FIN: begin
				NAND_CE_N <= 1'b1;
				DONE      <= 1'b1;
				READY     <= 1'b1;
				st_q      <= S_IDLE;
			end
			default: begin
				st_q <= S_IDLE;
			end
			endcase
		end
	end

endmodule

// ==== logic/nfp_consts.vh ====
// Constants for the host-side NAND feature and protect controller
// Contract
// - Feature read uses command EEh, write uses EFh, each with one address.
// - After polling status in a feature read, issue read command first.
// - After busy ends, host pulses read strobe once per byte.
// - Feature write sends four bytes, captured on write strobe rise.
// - Host settles write-protect a setup time before the first command.
// - Host waits at least one millisecond after power-up.
// - Host holds write-protect low during power transitions.
`ifndef NFP_CONSTS_VH
`define NFP_CONSTS_VH
`define NFP_CMD_GET_FEAT 8'hEE
`define NFP_CMD_SET_FEAT 8'hEF
`define NFP_CMD_STATUS   8'h70
`define NFP_CMD_READ     8'h00
`define NFP_FA_DRIVE     8'h80
`define NFP_FA_PULLDOWN  8'h81
`define NFP_SR_READY_BIT 6
`define NFP_SR_FAIL_BIT  0
`define NFP_CLK_NS       100
`define NFP_PWRUP_NS     1000000
`define NFP_PWRUP_CYC    ((`NFP_PWRUP_NS + `NFP_CLK_NS - 1) / `NFP_CLK_NS)
`define NFP_WP_SETUP_NS  100
`define NFP_WP_SETUP_CYC ((`NFP_WP_SETUP_NS + `NFP_CLK_NS - 1) / `NFP_CLK_NS)
`define NFP_RHW_NS       100
`define NFP_RHW_CYC      ((`NFP_RHW_NS + `NFP_CLK_NS - 1) / `NFP_CLK_NS)
`endif

// ==== test/nfp_chk_chk.sv ====
// Pin checker for the host feature controller
module nfp_chk #(parameter int PWRUP_CYC = 20) (
	input wire logic       CLK, RST, READY, NAND_CE_N, NAND_CLE,
	input wire logic       NAND_ALE, NAND_WE_N, READ_STROBE_N,
	input wire logic       NAND_WP_N, NAND_RB_N, NAND_IO_OE,
	input wire logic [7:0] NAND_IO_O
);
	timeunit 1ns;
	timeprecision 1ns;
	int n;
	always_ff @(posedge CLK or posedge RST)
		if (RST) n <= 0;
		else if (n < PWRUP_CYC) n <= n + 1;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_addr;
		!NAND_WE_N ##1 NAND_ALE && NAND_WE_N;
	endsequence
	a_cmd_code: assert property (NAND_CLE && !NAND_WE_N |->
		NAND_IO_OE && NAND_IO_O inside {8'hEE, 8'hEF})
		else $error("bad command byte");
	a_one_addr: assert property ($rose(NAND_ALE) |->
		s_addr ##1 !NAND_ALE) else $error("bad address cycle");
	a_data_drive: assert property (!NAND_WE_N |->
		NAND_IO_OE && !NAND_CE_N) else $error("write not driven");
	a_read_ready: assert property (!READ_STROBE_N |->
		NAND_RB_N && !NAND_IO_OE) else $error("read while busy");
	a_strobe_once: assert property ($fell(READ_STROBE_N) |=>
		READ_STROBE_N) else $error("long read strobe");
	a_wp_steady: assert property (!READY ##1 !READY |->
		$stable(NAND_WP_N)) else $error("protect moved");
	a_pwrup_wait: assert property (!NAND_CE_N |->
		n >= PWRUP_CYC) else $error("early command");
	a_pwrup_wp: assert property (n < PWRUP_CYC |->
		!NAND_WP_N) else $error("protect high at power-up");
endmodule
bind nfp_host_ctrl nfp_chk #(.PWRUP_CYC(PWRUP_CYC)) nfp_chk_i (.CLK,
	.RST, .READY, .NAND_CE_N, .NAND_CLE, .NAND_ALE, .NAND_WE_N,
	.READ_STROBE_N, .NAND_WP_N, .NAND_RB_N, .NAND_IO_OE, .NAND_IO_O);

// ==== test/nfp_dev_model.sv ====
// Behavioural NAND feature table model
module nfp_dev_model #(parameter int BUSY_CYC = 5) (
	input wire logic       CLK, ce_n, cle, ale, we_n, re_n, wp_n,
	input wire logic [7:0] d,
	output logic           rb_n = 1'b1,
	output logic     [7:0] q = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  cmd, fa;
	logic [31:0] p, output_drive_strength = 0, busy_pulldown_strength = 0;
	int i;
	// ready in bits 6 and 5, protect in bit 7, fail bit 0 clear
	wire [7:0] status_byte = {wp_n, rb_n, rb_n, 5'h00};
	task automatic busy;
		rb_n = 0;
		repeat (BUSY_CYC) @(posedge CLK);
		rb_n = 1;
	endtask
	always @(posedge we_n) if (!ce_n) begin
		if (cle) begin
			cmd = d;
			i = 0;
			// reset command leaves both strength values alone
			if (d == 8'hFF) busy();
		end else if (ale) begin
			fa = d;
			p = fa == 8'h80 ? output_drive_strength :
				fa == 8'h81 ? busy_pulldown_strength : 0;
			if (cmd == 8'hEE) busy();
		end else if (cmd == 8'hEF) begin
			// feature writes are not program or erase: WP never gates
			p[i*8 +: 8] = d;
			i++;
			if (i == 4) begin
				if (fa == 8'h80) output_drive_strength = {30'h0, p[1:0]};
				if (fa == 8'h81) busy_pulldown_strength = {30'h0, p[1:0]};
				busy();
			end
		end
	end
	// bytes in order; a released line shows garbage
	always @(negedge re_n) begin
		q = cmd == 8'h70 ? status_byte : p[i*8 +: 8];
		i++;
	end
	always @(posedge re_n) q <= #20 ~q;
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the host feature controller
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK = 0, RST = 1, gt = 0, st = 0, wpe = 0;
	logic [7:0] ad = 0;
	logic [31:0] wd = 0;
	wire READY, DONE, ce_n, cle, ale, we_n, re_n, wp_n, oe, rb_n;
	wire [31:0] RDATA;
	wire [7:0] io_o, io_i;
	int bad_count = 0, compares = 0;
	nfp_host_ctrl #(.PWRUP_CYC(20)) nfp_host_ctrl_i (.CLK, .RST,
		.REQ_GET(gt), .REQ_SET(st), .REQ_ADDR(ad), .REQ_WDATA(wd),
		.WP_ENABLE(wpe), .READY, .DONE, .RDATA, .NAND_CE_N(ce_n),
		.NAND_CLE(cle), .NAND_ALE(ale), .NAND_WE_N(we_n),
		.READ_STROBE_N(re_n), .NAND_WP_N(wp_n), .NAND_RB_N(rb_n),
		.NAND_IO_I(io_i), .NAND_IO_O(io_o), .NAND_IO_OE(oe));
	nfp_dev_model nfp_dev_model_i (.CLK, .ce_n, .cle, .ale, .we_n,
		.re_n, .wp_n, .d(io_o), .rb_n, .q(io_i));
	initial forever #50 CLK = ~CLK;
	task report_and_stop;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task cmp(string n, logic [31:0] e, s);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	task op(logic g, logic [7:0] a, logic [31:0] w);
		int k;
		k = 0;
		@(posedge CLK);
		gt <= g;
		st <= !g;
		ad <= a;
		wd <= w;
		@(posedge CLK);
		gt <= 0;
		st <= 0;
		do begin
			@(posedge CLK);
			#1;
			k++;
		end while (DONE !== 1'b1 && k < 999);
	endtask
	task rd(logic [7:0] a, logic [31:0] e);
		op(1, a, 0);
		cmp("RDATA", e, RDATA);
	endtask
	initial begin
		repeat (12) @(posedge CLK);
		RST <= 0;
		wait (READY === 1'b1);
		rd(8'h80, 0);
		cmp("NAND_WP_N", 1, wp_n);
		rd(8'h81, 0);
		for (logic [31:0] v = 0; v < 4; v++) begin
			op(0, 8'h80, v);
			op(0, 8'h81, 3 - v);
			rd(8'h80, v);
			rd(8'h81, 3 - v);
		end
		op(0, 8'h80, 32'hFFFFFFFF);
		op(0, 8'h82, 1);
		rd(8'h82, 0);
		@(posedge CLK) wpe <= 1;
		rd(8'h80, 3);
		cmp("NAND_WP_N", 0, wp_n);
		op(0, 8'h81, 2);
		rd(8'h81, 2);
		@(posedge CLK) RST <= 1;
		repeat (3) @(posedge CLK);
		RST <= 0;
		wait (READY === 1'b1);
		rd(8'h81, 2);
		cmp("NAND_WP_N", 0, wp_n);
		report_and_stop;
	end
	initial begin
		repeat (9000) @(posedge CLK);
		bad_count++;
		report_and_stop;
	end
endmodule
